/* hw/pdse_pkg.sv */
// Shared constants for the presence-detect store read engine
`default_nettype none
package pdse_pkg;
  localparam int          DATA_W       = 8;
  localparam int          ADDR_W       = 8;
  localparam int          MEM_DEPTH    = 256;
  localparam int          FIFO_DEPTH   = 8;
  localparam int          LOAD_W       = ADDR_W + DATA_W;
  localparam logic [3:0]  TYPE_CODE    = 4'hA;
  localparam logic [3:0]  BITS_IN_BYTE = 4'h8;
  localparam logic [3:0]  BIT_CNT_RST  = 4'h0;
  localparam logic [3:0]  BIT_CNT_TX0  = 4'h1;
  localparam logic [7:0]  ADDR_RST     = 8'h00;
  localparam logic [7:0]  ADDR_STEP    = 8'h01;

  typedef enum logic [8:0] {
    PDSE_IDLE      = 9'h001,
    PDSE_ADDR      = 9'h002,
    PDSE_ADDR_ACK  = 9'h004,
    PDSE_WADDR     = 9'h008,
    PDSE_WADDR_ACK = 9'h010,
    PDSE_WDATA     = 9'h020,
    PDSE_WDATA_ACK = 9'h040,
    PDSE_RDATA     = 9'h080,
    PDSE_RACK      = 9'h100
  } pdse_state_t;
endpackage
`default_nettype wire

/* hw/pdse_stream_if.sv */
// Valid/ready stream carrier between the engine and its FIFO
`default_nettype none
interface pdse_stream_if #(parameter int W = 16);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* hw/pdse_fifo.sv */
// Synchronous FIFO with registered full and empty flags
`default_nettype none
module pdse_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 8
) (
  input  wire logic   clk,
  input  wire logic   rstn,
  pdse_stream_if.snk  in_s,
  pdse_stream_if.src  out_s
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [PW:0]   cnt_q, cnt_d;
  logic          full_q, full_d, empty_q, empty_d;
  logic          push, pop;

  assign push        = in_s.valid && !full_q;
  assign pop         = out_s.ready && !empty_q;
  assign in_s.ready  = !full_q;
  assign out_s.valid = !empty_q;
  assign out_s.data  = mem[rd_q];

  always_comb begin
    wr_d = push ? PW'((wr_q + 1'b1) % DEPTH) : wr_q;
    rd_d = pop ? PW'((rd_q + 1'b1) % DEPTH) : rd_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
    full_d  = (cnt_d == DEPTH_C);
    empty_d = (cnt_d == '0);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_q    <= '0;
      rd_q    <= '0;
      cnt_q   <= '0;
      full_q  <= 1'b0;
      empty_q <= 1'b1;
    end else begin
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      cnt_q   <= cnt_d;
      full_q  <= full_d;
      empty_q <= empty_d;
    end
  end

  // Storage needs no reset; only written words are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_s.data;
    end
  end
endmodule // pdse_fifo
`default_nettype wire

/* hw/pdse_read_engine.sv */
// Two-wire target for the presence-detect store: read engine with address counter
`default_nettype none
// Functional notes
// - Counter holds last accessed location plus one after any read or write
// - Read address with no word address: acknowledge, then send byte at counter
// - After repeated start and read address, acknowledge and send the selected byte
// - Every master acknowledge brings another byte from the next location
// - Counter wraps from 255 to 0 and reading continues
// - Accept only type code 1010 plus matching select straps, then acknowledge
// - No acknowledge after a byte: release data line until next start
module pdse_read_engine (
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire logic                    scl_in,
  input  wire logic                    sda_in,
  output var  logic                    sda_out,
  output var  logic                    sda_oe,
  input  wire logic [2:0]              module_select_straps,
  input  wire logic                    load_valid,
  input  wire logic [pdse_pkg::ADDR_W-1:0] load_addr,
  input  wire logic [pdse_pkg::DATA_W-1:0] load_data,
  output var  logic                    load_ready,
  output var  logic                    busy
);
  function automatic logic addr_match(input logic [6:0] a, input logic [2:0] sel);
    return (a[6:3] == pdse_pkg::TYPE_CODE) && (a[2:0] == sel);
  endfunction

  pdse_stream_if #(.W(pdse_pkg::LOAD_W)) load_in ();
  pdse_stream_if #(.W(pdse_pkg::LOAD_W)) load_out ();

  pdse_fifo #(.W(pdse_pkg::LOAD_W), .DEPTH(pdse_pkg::FIFO_DEPTH)) u_fifo (
    .clk   (clk),
    .rstn  (rstn),
    .in_s  (load_in.snk),
    .out_s (load_out.src)
  );

  logic [pdse_pkg::DATA_W-1:0] mem [pdse_pkg::MEM_DEPTH];

  // Pin synchronisers; third stage only for edge detection
  logic [1:0] scl_sy_q, sda_sy_q;
  logic [2:0] sel_s1_q, sel_s2_q;
  logic       scl_p_q, sda_p_q;
  logic       scl_rise, scl_fall, start_ev, stop_ev;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_sy_q <= 2'h3;
      sda_sy_q <= 2'h3;
      scl_p_q  <= 1'b1;
      sda_p_q  <= 1'b1;
      sel_s1_q <= 3'h0;
      sel_s2_q <= 3'h0;
    end else begin
      scl_sy_q <= {scl_sy_q[0], scl_in};
      sda_sy_q <= {sda_sy_q[0], sda_in};
      scl_p_q  <= scl_sy_q[1];
      sda_p_q  <= sda_sy_q[1];
      sel_s1_q <= module_select_straps;
      sel_s2_q <= sel_s1_q;
    end
  end

  assign scl_rise = scl_sy_q[1] && !scl_p_q;
  assign scl_fall = !scl_sy_q[1] && scl_p_q;
  assign start_ev = scl_sy_q[1] && scl_p_q && sda_p_q && !sda_sy_q[1];
  assign stop_ev  = scl_sy_q[1] && scl_p_q && !sda_p_q && sda_sy_q[1];

  pdse_pkg::pdse_state_t       state_q, state_d;
  logic [3:0]                  bitn_q, bitn_d;
  logic [pdse_pkg::DATA_W-1:0] shreg_q, shreg_d;
  logic [pdse_pkg::ADDR_W-1:0] cnt_q, cnt_d;
  logic                        oe_q, oe_d;
  logic                        rw_q, rw_d;
  logic                        ack_q, ack_d;
  logic                        busy_q, busy_d;
  logic                        ready_q;
  logic                        mem_we;
  logic [pdse_pkg::ADDR_W-1:0] mem_wa;
  logic [pdse_pkg::DATA_W-1:0] mem_wd;
  logic [pdse_pkg::DATA_W-1:0] rd_byte;

  assign rd_byte        = mem[cnt_q];
  assign load_in.valid  = load_valid;
  assign load_in.data   = {load_addr, load_data};
  // Loader only touches the array while the bus is quiet; a bus event in
  // that cycle skips the array write, so the word must stay in the FIFO
  assign load_out.ready = (state_q == pdse_pkg::PDSE_IDLE) && !start_ev && !stop_ev;

  always_comb begin
    state_d = state_q;
    bitn_d  = bitn_q;
    shreg_d = shreg_q;
    cnt_d   = cnt_q;
    oe_d    = oe_q;
    rw_d    = rw_q;
    ack_d   = ack_q;
    mem_we  = 1'b0;
    mem_wa  = cnt_q;
    mem_wd  = shreg_q;
    if (stop_ev) begin
      state_d = pdse_pkg::PDSE_IDLE;
      oe_d    = 1'b0;
    end else if (start_ev) begin
      state_d = pdse_pkg::PDSE_ADDR;
      bitn_d  = pdse_pkg::BIT_CNT_RST;
      oe_d    = 1'b0;
    end else begin
      unique case (state_q)
        pdse_pkg::PDSE_IDLE: begin
          if (load_out.valid) begin
            mem_we = 1'b1;
            mem_wa = load_out.data[pdse_pkg::LOAD_W-1:pdse_pkg::DATA_W];
            mem_wd = load_out.data[pdse_pkg::DATA_W-1:0];
          end
        end
        pdse_pkg::PDSE_ADDR, pdse_pkg::PDSE_WADDR, pdse_pkg::PDSE_WDATA: begin
          if (scl_rise && bitn_q != pdse_pkg::BITS_IN_BYTE) begin
            shreg_d = {shreg_q[6:0], sda_sy_q[1]};
            bitn_d  = bitn_q + 1'b1;
          end else if (scl_fall && bitn_q == pdse_pkg::BITS_IN_BYTE) begin
            oe_d = 1'b1;
            if (state_q == pdse_pkg::PDSE_ADDR) begin
              if (addr_match(shreg_q[7:1], sel_s2_q)) begin
                rw_d    = shreg_q[0];
                state_d = pdse_pkg::PDSE_ADDR_ACK;
              end else begin
                oe_d    = 1'b0;
                state_d = pdse_pkg::PDSE_IDLE;
              end
            end else if (state_q == pdse_pkg::PDSE_WADDR) begin
              cnt_d   = shreg_q;
              state_d = pdse_pkg::PDSE_WADDR_ACK;
            end else begin
              mem_we  = 1'b1;
              cnt_d   = cnt_q + pdse_pkg::ADDR_STEP;
              state_d = pdse_pkg::PDSE_WDATA_ACK;
            end
          end
        end
        pdse_pkg::PDSE_ADDR_ACK, pdse_pkg::PDSE_WADDR_ACK, pdse_pkg::PDSE_WDATA_ACK: begin
          if (scl_fall) begin
            oe_d   = 1'b0;
            bitn_d = pdse_pkg::BIT_CNT_RST;
            if (state_q == pdse_pkg::PDSE_ADDR_ACK && rw_q) begin
              // First byte comes straight from the counter
              shreg_d = rd_byte;
              oe_d    = !rd_byte[7];
              cnt_d   = cnt_q + pdse_pkg::ADDR_STEP;
              bitn_d  = pdse_pkg::BIT_CNT_TX0;
              state_d = pdse_pkg::PDSE_RDATA;
            end else if (state_q == pdse_pkg::PDSE_ADDR_ACK) begin
              state_d = pdse_pkg::PDSE_WADDR;
            end else begin
              state_d = pdse_pkg::PDSE_WDATA;
            end
          end
        end
        pdse_pkg::PDSE_RDATA: begin
          if (scl_fall) begin
            if (bitn_q == pdse_pkg::BITS_IN_BYTE) begin
              oe_d    = 1'b0;
              state_d = pdse_pkg::PDSE_RACK;
            end else begin
              shreg_d = {shreg_q[6:0], 1'b0};
              oe_d    = !shreg_q[6];
              bitn_d  = bitn_q + 1'b1;
            end
          end
        end
        pdse_pkg::PDSE_RACK: begin
          if (scl_rise) begin
            ack_d = !sda_sy_q[1];
          end else if (scl_fall) begin
            if (ack_q) begin
              // Counter wraps naturally at the top of the array
              shreg_d = rd_byte;
              oe_d    = !rd_byte[7];
              cnt_d   = cnt_q + pdse_pkg::ADDR_STEP;
              bitn_d  = pdse_pkg::BIT_CNT_TX0;
              state_d = pdse_pkg::PDSE_RDATA;
            end else begin
              oe_d    = 1'b0;
              state_d = pdse_pkg::PDSE_IDLE;
            end
          end
        end
      endcase
    end
    busy_d = (state_d != pdse_pkg::PDSE_IDLE);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= pdse_pkg::PDSE_IDLE;
      bitn_q  <= pdse_pkg::BIT_CNT_RST;
      shreg_q <= 8'h00;
      cnt_q   <= pdse_pkg::ADDR_RST;
      oe_q    <= 1'b0;
      rw_q    <= 1'b0;
      ack_q   <= 1'b0;
      busy_q  <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bitn_q  <= bitn_d;
      shreg_q <= shreg_d;
      cnt_q   <= cnt_d;
      oe_q    <= oe_d;
      rw_q    <= rw_d;
      ack_q   <= ack_d;
      busy_q  <= busy_d;
      ready_q <= load_in.ready;
    end
  end

  // Array content is undefined until loaded or written over the bus
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // Open drain: the pin is only ever pulled low
  assign sda_out    = 1'b0;
  assign sda_oe     = oe_q;
  assign busy       = busy_q;
  assign load_ready = ready_q;
endmodule // pdse_read_engine
`default_nettype wire

/* sim/pdse_read_engine_props.sv */
// Port checker for the presence-detect store read engine
`default_nettype none
module pdse_read_engine_props (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe,
  input wire logic load_valid,
  input wire logic load_ready,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_start; scl_in && $past(scl_in) && $fell(sda_in); endsequence
  sequence s_stop; scl_in && $past(scl_in) && $rose(sda_in); endsequence
  property p_start; s_start |-> ##[1:6] busy; endproperty
  property p_stop; s_stop |-> ##[1:6] !busy; endproperty
  property p_oe_edge; $changed(sda_oe) |-> !scl_in; endproperty
  property p_oe_hold; $rose(sda_oe) |-> sda_oe [*6]; endproperty
  property p_oe_busy; sda_oe |-> busy; endproperty
  property p_idle_rel; $fell(busy) |-> !sda_oe; endproperty
  property p_drain; !busy && !load_ready && !load_valid |-> ##[1:12] load_ready; endproperty
  property p_full; $fell(load_ready) |-> busy; endproperty
  a_start: assert property (p_start) else $error("start did not wake engine");
  a_stop: assert property (p_stop) else $error("stop did not idle engine");
  a_oe_edge: assert property (p_oe_edge) else $error("data line moved with clock high");
  a_oe_hold: assert property (p_oe_hold) else $error("driven bit too short");
  a_oe_busy: assert property (p_oe_busy) else $error("line driven while idle");
  a_idle_rel: assert property (p_idle_rel) else $error("idle with line held");
  a_drain: assert property (p_drain) else $error("idle engine did not drain");
  a_full: assert property (p_full) else $error("buffer filled while idle");
endmodule // pdse_read_engine_props
bind pdse_read_engine pdse_read_engine_props chk_u (.clk(clk), .rstn(rstn), .scl_in(scl_in),
  .sda_in(sda_in), .sda_oe(sda_oe), .load_valid(load_valid), .load_ready(load_ready),
  .busy(busy));
`default_nettype wire

/* sim/pdse_i2c_master.sv */
// Behavioural two-wire bus master facing the engine
`default_nettype none
module pdse_i2c_master (
  output var  logic scl,
  output var  logic sda_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // 160 ns slot; line read late in the high phase to allow device delay
  task automatic bit_io(input logic b, output logic r);
    #40 sda_low = !b;
    #40 scl = 1'b1;
    #70 r = sda;
    #10 scl = 1'b0;
  endtask
  task automatic start();
    #40 sda_low = 1'b0;
    #40 scl = 1'b1;
    #80 sda_low = 1'b1;
    #80 scl = 1'b0;
  endtask
  task automatic stop();
    #40 sda_low = 1'b1;
    #40 scl = 1'b1;
    #80 sda_low = 1'b0;
    #80;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!ack, r);
  endtask
endmodule // pdse_i2c_master
`default_nettype wire

/* sim/pdse_read_engine_test.sv */
// Self-checking bench for the presence-detect store read engine
`default_nettype none
module pdse_read_engine_test;
  timeunit 1ns;
  timeprecision 1ps;
  // Row: random or current read, word address, byte count, last byte expected
  typedef struct {logic rnd; logic [7:0] word; int n; logic [7:0] last;} pdse_row_t;
  logic       clk, rstn, scl, m_low, sda, s_out, sda_oe, load_valid, load_ready, busy, ack;
  logic [7:0] load_addr, load_data, ptr, d, key;
  logic [2:0] straps;
  int         err_count, total_checks;
  pdse_row_t  rows [4] = '{'{1'b1, 8'h10, 2, 8'h4B}, '{1'b0, 8'h00, 1, 8'h48},
                           '{1'b1, 8'hFE, 4, 8'h5B}, '{1'b0, 8'h00, 1, 8'h58}};
  // Pull-up on the shared data line
  assign sda = (sda_oe || m_low) ? 1'b0 : 1'b1;
  pdse_read_engine dut_u (.clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(s_out),
    .sda_oe(sda_oe), .module_select_straps(straps), .load_valid(load_valid),
    .load_addr(load_addr), .load_data(load_data), .load_ready(load_ready), .busy(busy));
  pdse_i2c_master mst_u (.scl(scl), .sda_low(m_low), .sda(sda));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic reset_dut();
    rstn = 1'b0;
    repeat (5) @(negedge clk);
    check({4'h0, s_out, sda_oe, busy, load_ready}, 8'h00);
    rstn = 1'b1;
    ptr = 8'h00;
    repeat (2) @(negedge clk);
  endtask
  task automatic push(input logic [7:0] a);
    load_valid = 1'b1;
    load_addr = a;
    load_data = a ^ key;
  endtask
  task automatic wr(input logic [7:0] b, input logic exp);
    mst_u.wbyte(b, ack);
    check({7'h00, ack}, {7'h00, exp});
  endtask
  task automatic rd(input logic more);
    mst_u.rbyte(more, d);
    check(d, ptr ^ key);
    ptr = ptr + 8'h01;
  endtask
  task automatic xfer(input logic rnd, input logic [7:0] w, input int n);
    mst_u.start();
    if (rnd) begin
      wr(8'hAA, 1'b1);
      wr(w, 1'b1);
      ptr = w;
      mst_u.start();
    end
    wr(8'hAB, 1'b1);
    for (int i = 0; i < n; i++) rd(i < n - 1);
    mst_u.stop();
  endtask
  initial begin
    rstn = 1'b0;
    key = 8'h5A;
    straps = 3'h5;
    load_valid = 1'b0;
    load_addr = 8'h00;
    load_data = 8'h00;
    reset_dut();
    for (int a = 0; a < 256; a++) begin
      @(negedge clk);
      push(8'(a));
      @(negedge clk);
      load_valid = 1'b0;
    end
    foreach (rows[i]) begin
      xfer(rows[i].rnd, rows[i].word, rows[i].n);
      check(d, rows[i].last);
    end
    // A written data byte also moves the counter
    mst_u.start();
    wr(8'hAA, 1'b1);
    wr(8'h20, 1'b1);
    wr(8'h20 ^ 8'h5A, 1'b1);
    mst_u.stop();
    ptr = 8'h21;
    xfer(1'b0, 8'h00, 1);
    mst_u.start();
    wr(8'hA5, 1'b0);
    mst_u.stop();
    mst_u.start();
    wr(8'hBB, 1'b0);
    mst_u.stop();
    // Moved straps move the address that is answered
    straps = 3'h2;
    mst_u.start();
    wr(8'hA4, 1'b1);
    mst_u.stop();
    straps = 3'h5;
    mst_u.start();
    wr(8'hAB, 1'b1);
    rd(1'b0);
    mst_u.rbyte(1'b0, d);
    check(d, 8'hFF);
    mst_u.stop();
    // Fill while the engine is busy mid-read and the master holds the clock low; ninth word must be dropped
    mst_u.start();
    wr(8'hAB, 1'b1);
    // New contents differ from the preload so a lost word shows up
    key = 8'hC3;
    for (int k = 0; k < 9; k++) begin
      @(negedge clk);
      push(8'h40 + 8'(k));
      if (k == 8) load_data = 8'h00;
    end
    @(negedge clk);
    load_valid = 1'b0;
    key = 8'h5A;
    repeat (2) @(negedge clk);
    check({6'h00, busy, load_ready}, 8'h02);
    rd(1'b0);
    mst_u.stop();
    key = 8'hC3;
    xfer(1'b1, 8'h40, 8);
    key = 8'h5A;
    xfer(1'b1, 8'h48, 1);
    reset_dut();
    xfer(1'b0, 8'h00, 1);
    final_report();
  end
  initial begin
    #1000000;
    err_count++;
    final_report();
  end
endmodule // pdse_read_engine_test
`default_nettype wire
